// >>> shared/tsi_pkg.sv
/*
 * Constants, field layout and state types of the time-slot switch core.
 * Assumes a single 100 MHz core clock that oversamples the serial master clock.
 */
package tsi_pkg;
    localparam int          STREAMS        = 16;
    localparam int          STRM_W         = 4;
    localparam int          CH_W           = 7;
    localparam int          OFF_W          = 4;
    localparam int          HIST_W         = 8;
    localparam int          CM_DEPTH       = 2048;
    localparam int          DM_DEPTH       = 6144;
    localparam int          FIFO_DEPTH     = 16;
    localparam int          FIFO_W         = 21;
    // -----------------------------------------------------------------
    // Connection memory word
    // -----------------------------------------------------------------
    localparam int          CM_LOOP_BACK_BIT        = 15;
    localparam int          CM_CONST       = 14;
    localparam int          CM_PROC        = 13;
    localparam int          CM_OE          = 12;
    localparam int          CM_CCO         = 11;
    localparam int          CM_SRC_STRM_LO = 7;
    localparam logic [15:0] CM_RESET       = 16'h0000;
    // -----------------------------------------------------------------
    // Rates, selects and timing counts
    // -----------------------------------------------------------------
    localparam logic [1:0]  RATE_4M        = 2'h1;
    localparam logic [1:0]  RATE_8M        = 2'h2;
    localparam logic [9:0]  BIT_LAST_2M    = 10'h0ff;
    localparam logic [9:0]  BIT_LAST_4M    = 10'h1ff;
    localparam logic [9:0]  BIT_LAST_8M    = 10'h3ff;
    localparam logic [1:0]  MS_CM          = 2'h1;
    localparam logic [1:0]  MS_DM          = 2'h2;
    localparam logic [1:0]  PH_SAMPLE      = 2'h2;
    localparam logic [1:0]  PH_LAST        = 2'h3;
    localparam logic [2:0]  BIT_LAST_CH    = 3'h7;
    localparam logic [2:0]  IDLE_EDGES     = 3'h4;
    localparam logic [3:0]  OFF_MAX        = 4'h8;
    localparam logic [7:0]  VAR_LEAD       = 8'h03;
    localparam logic [1:0]  PAGE_LAST      = 2'h2;

    typedef enum logic [1:0] {
        F_IDLE = 2'b01,
        F_RUN  = 2'b10
    } fetch_state_t;

    function automatic logic [1:0] inc3(input logic [1:0] p);
        return (p == PAGE_LAST) ? 2'h0 : p + 2'h1;
    endfunction
endpackage

// >>> logic/tsi_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two; one clock, asynchronous active-low reset.
 */
`timescale 1ns/1ps
module tsi_fifo #(
    parameter int W     = 21,
    parameter int DEPTH = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [0:DEPTH-1];
    logic [AW:0]  wr_reg;
    logic [AW:0]  rd_reg;

    wire          push  = in_valid & in_ready;
    wire          pop   = out_valid & out_ready;
    wire [AW:0]   level = wr_reg - rd_reg;

    // Extra pointer bit tells full from empty
    assign in_ready  = level != (AW+1)'(DEPTH);
    assign out_valid = wr_reg != rd_reg;
    assign out_data  = mem[rd_reg[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule

// >>> logic/tsi_core.sv
/*
 * Time-slot interchange core: 16 serial streams in, data memory, connection
 * memory, 16 serial streams out plus control bit output.
 * Assumes master clock, frame pulse and serial inputs synchronous to REF_CLK
 * and far slower than it; host port is a plain strobe interface.
 */
// What this block does
// [RULE1] Streams carry 32, 64 or 128 channels
// [RULE2] Inputs and outputs share one bit rate
// [RULE3] Frame pulse polarity picks edge format
// [RULE4] Received bytes written sequentially to data memory
// [RULE5] Frame pulse sets channel and frame boundaries
// [RULE6] Byte from data or connection memory
// [RULE7] Fetch byte one channel ahead
// [RULE8] Each entry maps one output, names source
// [RULE9] Many outputs may share one source
// [RULE10] Processor byte repeats every frame
// [RULE11] Five control bits per entry
// [RULE12] Disabled channel high impedance for its slot
// [RULE13] Drive pin or standby force all off
// [RULE14] Host access decoded from address, select
// [RULE15] Master clock twice the bit rate
// [RULE16] Wide pulse pin forces falling-edge alignment
// [RULE17] Falling format: sample rising, three quarters
// [RULE18] GCI format: sample falling, three quarters
// [RULE19] Wide mode needs fixed clocks, frame format
// [RULE20] Wide mode keeps input offsets working
// [RULE21] Per-stream programmable input offset
// [RULE22] Diagnostic loopback output into input
// [RULE23] Loopback maps stream n channel m
// [RULE24] Variable delay: within three, next frame
// [RULE25] Constant delay: frame n out n+2
// [RULE26] Control output twice bit rate per entry
// [RULE27] Frame pulse restarts bit and channel counters
`timescale 1ns/1ps
module tsi_core (
    input  wire logic        REF_CLK,
    input  wire logic        RST_B,
    input  wire logic        MASTER_CLK,
    input  wire logic        FRAME_SYNC_IN,
    input  wire logic [15:0] RX_STREAMS,
    input  wire logic [1:0]  DATA_RATE,
    input  wire logic        OUTPUT_DRIVE_ENABLE_PIN,
    input  wire logic        OUTPUT_STANDBY_BIT,
    input  wire logic        WIDE_PULSE_SELECT_PIN,
    input  wire logic [63:0] FRAME_OFFSET,
    input  wire logic [1:0]  MEMORY_SELECT_BIT,
    input  wire logic [3:0]  HOST_STREAM,
    input  wire logic [7:0]  HOST_ADDR,
    input  wire logic        HOST_WR,
    input  wire logic        HOST_RD,
    input  wire logic [15:0] HOST_WDATA,
    output logic [15:0]      SERIAL_OUT_STREAMS,
    output logic [15:0]      SERIAL_OUT_OE,
    output logic             CONTROL_BIT_OUTPUT,
    output logic [15:0]      HOST_RDATA,
    output logic             HOST_ACK,
    output logic             GCI_FORMAT,
    output logic             WIDE_PULSE_ALIGNMENT_MODE
);
    localparam int S = tsi_pkg::STREAMS;

    // -----------------------------------------------------------------
    // Master clock phase and frame timing
    // -----------------------------------------------------------------
    logic       mclk_reg;
    logic       fs_lvl_reg;
    logic [2:0] run_reg;
    logic       fp_prev_reg;
    logic [1:0] ph_reg;
    logic [9:0] bit_reg;
    logic [1:0] page_reg;

    wire mclk_rise = MASTER_CLK & ~mclk_reg;
    wire mclk_fall = ~MASTER_CLK & mclk_reg;
    wire edge_any  = mclk_rise | mclk_fall;
    wire bnd_edge  = GCI_FORMAT ? mclk_rise : mclk_fall;            // [RULE17]
    wire fp_act    = GCI_FORMAT ? FRAME_SYNC_IN : ~FRAME_SYNC_IN;   // [RULE3]
    wire frame_pulse = bnd_edge & fp_act & ~fp_prev_reg;            // [RULE5]
    wire [9:0] bit_last = (DATA_RATE == tsi_pkg::RATE_8M) ? tsi_pkg::BIT_LAST_8M :
                          (DATA_RATE == tsi_pkg::RATE_4M) ? tsi_pkg::BIT_LAST_4M :
                          tsi_pkg::BIT_LAST_2M;                     // [RULE1]
    wire bit_step   = bnd_edge & (ph_reg == tsi_pkg::PH_LAST);
    wire frame_wrap = frame_pulse | (bit_step & (bit_reg == bit_last));
    // Sample edge is opposite to the boundary edge, three quarters in
    wire smp        = edge_any & (ph_reg == tsi_pkg::PH_SAMPLE) & ~frame_pulse; // [RULE18]
    wire chan_start = frame_wrap | (bit_step & (bit_reg[2:0] == tsi_pkg::BIT_LAST_CH));
    wire [6:0] ch_now  = bit_reg[9:3];
    wire [6:0] ch_last = bit_last[9:3];
    wire [6:0] ch_new  = frame_wrap ? 7'h00 : ch_now + 7'h01;
    wire [1:0] page_new = frame_wrap ? tsi_pkg::inc3(page_reg) : page_reg;
    wire fetch_wrap = ch_new == ch_last;
    wire [6:0] fch_new = fetch_wrap ? 7'h00 : ch_new + 7'h01;
    wire [1:0] fpg_new = fetch_wrap ? tsi_pkg::inc3(page_new) : page_new;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mclk_reg    <= 1'b0;
            fs_lvl_reg  <= 1'b1;
            run_reg     <= 3'h0;
            fp_prev_reg <= 1'b0;
            WIDE_PULSE_ALIGNMENT_MODE <= 1'b0;
            GCI_FORMAT  <= 1'b0;
        end else begin
            mclk_reg <= MASTER_CLK;
            WIDE_PULSE_ALIGNMENT_MODE <= WIDE_PULSE_SELECT_PIN;
            if (bnd_edge) begin
                fp_prev_reg <= fp_act;
            end
            // Idle level lasts longer than the pulse, so it reveals polarity
            if (edge_any) begin
                fs_lvl_reg <= FRAME_SYNC_IN;
                run_reg <= (FRAME_SYNC_IN != fs_lvl_reg) ? 3'h0 :
                           (run_reg == tsi_pkg::IDLE_EDGES) ? run_reg : run_reg + 3'h1;
            end
            if (WIDE_PULSE_ALIGNMENT_MODE) begin
                GCI_FORMAT <= 1'b0;                                 // [RULE16]
            end else if (edge_any && run_reg == tsi_pkg::IDLE_EDGES) begin
                GCI_FORMAT <= ~fs_lvl_reg;                          // [RULE3]
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ph_reg   <= 2'h0;
            bit_reg  <= 10'h000;
            page_reg <= 2'h0;
        end else begin
            if (frame_pulse) begin
                ph_reg <= 2'h0;                                     // [RULE27]
            end else if (edge_any) begin
                ph_reg <= ph_reg + 2'h1;
            end
            if (frame_wrap) begin
                bit_reg <= 10'h000;                                 // [RULE27]
            end else if (bit_step) begin
                bit_reg <= bit_reg + 10'h001;
            end
            page_reg <= page_new;
        end
    end

    // -----------------------------------------------------------------
    // Receive path: offset, loopback, deserialise
    // -----------------------------------------------------------------
    logic [7:0]  tx_sh   [S];
    logic [4:0]  cur_ctl [S];
    logic [4:0]  nxt_ctl [S];
    logic [7:0]  nxt_byte[S];
    localparam int HIST_W_C = tsi_pkg::HIST_W;
    logic [HIST_W_C-1:0] hist[S];
    logic [7:0]  rsh [S];
    logic [7:0]  hold[S];
    logic [6:0]  hold_ch_reg;
    logic [1:0]  hold_pg_reg;
    logic        push_act_reg;
    logic [3:0]  push_idx_reg;

    logic [15:0] tap;
    logic [15:0] rx_pin;
    genvar g;
    generate
        for (g = 0; g < S; g++) begin : g_rx
            wire [3:0] off_raw = FRAME_OFFSET[g*4 +: 4];
            wire [3:0] off = (off_raw > tsi_pkg::OFF_MAX) ? tsi_pkg::OFF_MAX : off_raw;
            wire [8:0] taps = {hist[g], rx_pin[g]};
            // Loopback is only clean with zero offset on that stream
            assign rx_pin[g] = cur_ctl[g][4] ? tx_sh[g][7] : RX_STREAMS[g];  // [RULE23]
            assign tap[g] = taps[off];                              // [RULE21] [RULE20]
        end
    endgenerate

    wire capture = smp & (bit_reg[2:0] == tsi_pkg::BIT_LAST_CH);
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [20:0] fifo_out_data;
    wire [20:0] fifo_in_data = {hold_pg_reg, push_idx_reg, hold_ch_reg, hold[push_idx_reg]};

    always_ff @(posedge REF_CLK) begin
        for (int s = 0; s < S; s++) begin
            if (edge_any) begin
                hist[s] <= {hist[s][6:0], rx_pin[s]};
            end
            if (smp) begin
                rsh[s] <= {rsh[s][6:0], tap[s]};
            end
            if (capture) begin
                hold[s] <= {rsh[s][6:0], tap[s]};                   // [RULE4]
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            hold_ch_reg  <= 7'h00;
            hold_pg_reg  <= 2'h0;
            push_act_reg <= 1'b0;
            push_idx_reg <= 4'h0;
        end else if (capture) begin
            hold_ch_reg  <= ch_now;
            hold_pg_reg  <= page_reg;
            push_act_reg <= 1'b1;                                   // [RULE4]
            push_idx_reg <= 4'h0;
        end else if (push_act_reg && fifo_in_ready) begin
            push_idx_reg <= push_idx_reg + 4'h1;
            push_act_reg <= push_idx_reg != 4'hf;
        end
    end

    // Sixteen bytes land per channel; the FIFO decouples them from fetch reads
    tsi_fifo #(
        .W     (tsi_pkg::FIFO_W),
        .DEPTH (tsi_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (REF_CLK),
        .rst_b     (RST_B),
        .in_valid  (push_act_reg),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // -----------------------------------------------------------------
    // Memories, fetch sequencer and host port
    // -----------------------------------------------------------------
    logic [15:0] cm_mem [0:tsi_pkg::CM_DEPTH-1];
    logic [7:0]  dm_mem [0:tsi_pkg::DM_DEPTH-1];
    tsi_pkg::fetch_state_t fst_reg;
    logic [3:0]  fidx_reg;
    logic [6:0]  fch_reg;
    logic [1:0]  fpg_reg;
    logic        pv_reg;
    logic        pproc_reg;
    logic [3:0]  pidx_reg;
    logic [7:0]  pdata_reg;
    logic [7:0]  dm_q_reg;
    logic        hpend_reg;
    logic        hq_reg;

    wire fetch_run = fst_reg == tsi_pkg::F_RUN;
    wire [15:0] ent = cm_mem[{fidx_reg, fch_reg}];                  // [RULE8]
    wire [6:0]  src_ch = ent[6:0];
    wire [3:0]  src_st = ent[10:7];
    wire same_frame = ({1'b0, src_ch} + tsi_pkg::VAR_LEAD) <= {1'b0, fch_reg};
    wire [1:0] prev_pg = tsi_pkg::inc3(tsi_pkg::inc3(fpg_reg));
    wire [1:0] sel_pg = ent[tsi_pkg::CM_CONST] ? tsi_pkg::inc3(fpg_reg) : // [RULE25]
                        (same_frame ? fpg_reg : prev_pg);           // [RULE24]
    wire [12:0] f_addr = {sel_pg, src_st, src_ch};                  // [RULE9]
    wire host_mem = ~HOST_ADDR[7];
    wire [10:0] cm_waddr = {HOST_STREAM, HOST_ADDR[6:0]};
    wire cm_wr  = HOST_WR & host_mem & (MEMORY_SELECT_BIT == tsi_pkg::MS_CM); // [RULE14]
    wire dm_rd  = HOST_RD & host_mem & (MEMORY_SELECT_BIT == tsi_pkg::MS_DM);
    wire cm_rd  = HOST_RD & host_mem & (MEMORY_SELECT_BIT == tsi_pkg::MS_CM);
    wire [12:0] h_addr = {tsi_pkg::inc3(tsi_pkg::inc3(page_reg)), cm_waddr};
    wire host_go = hpend_reg & ~fetch_run;
    assign fifo_out_ready = ~fetch_run & ~hpend_reg;
    wire [12:0] w_addr = {fifo_out_data[20:19], fifo_out_data[18:15], fifo_out_data[14:8]};

    always_ff @(posedge REF_CLK) begin
        if (fetch_run) begin
            dm_q_reg <= dm_mem[f_addr];
        end else if (host_go) begin
            dm_q_reg <= dm_mem[h_addr];
        end else if (fifo_out_valid) begin
            dm_mem[w_addr] <= fifo_out_data[7:0];
        end
        if (cm_wr) begin
            cm_mem[cm_waddr] <= HOST_WDATA;                         // [RULE10]
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            fst_reg   <= tsi_pkg::F_IDLE;
            fidx_reg  <= 4'h0;
            fch_reg   <= 7'h00;
            fpg_reg   <= 2'h0;
            pv_reg    <= 1'b0;
            pproc_reg <= 1'b0;
            pidx_reg  <= 4'h0;
            pdata_reg <= 8'h00;
        end else begin
            pv_reg    <= fetch_run;
            pproc_reg <= ent[tsi_pkg::CM_PROC];
            pidx_reg  <= fidx_reg;
            pdata_reg <= ent[7:0];
            case (fst_reg)
                tsi_pkg::F_IDLE: begin
                    if (chan_start) begin
                        fst_reg  <= tsi_pkg::F_RUN;                 // [RULE7]
                        fidx_reg <= 4'h0;
                        fch_reg  <= fch_new;
                        fpg_reg  <= fpg_new;
                    end
                end
                tsi_pkg::F_RUN: begin
                    fidx_reg <= fidx_reg + 4'h1;
                    if (fidx_reg == 4'hf) begin
                        fst_reg <= tsi_pkg::F_IDLE;
                    end
                end
                default: fst_reg <= tsi_pkg::F_IDLE;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (fetch_run) begin
            // Loopback, output enable and control bit travel with the byte
            nxt_ctl[fidx_reg] <= {ent[tsi_pkg::CM_LOOP_BACK_BIT], ent[tsi_pkg::CM_OE],
                                  ent[tsi_pkg::CM_CCO], 2'b00};    // [RULE11]
        end
        if (pv_reg) begin
            nxt_byte[pidx_reg] <= pproc_reg ? pdata_reg : dm_q_reg; // [RULE6]
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            hpend_reg  <= 1'b0;
            hq_reg     <= 1'b0;
            HOST_ACK   <= 1'b0;
            HOST_RDATA <= 16'h0000;
        end else begin
            hq_reg <= host_go;
            if (dm_rd) begin
                hpend_reg <= 1'b1;
            end else if (host_go) begin
                hpend_reg <= 1'b0;
            end
            HOST_ACK <= hq_reg | (HOST_RD & ~dm_rd);
            if (hq_reg) begin
                HOST_RDATA <= {8'h00, dm_q_reg};
            end else if (HOST_RD) begin
                HOST_RDATA <= cm_rd ? cm_mem[cm_waddr] : 16'h0000;  // [RULE14]
            end
        end
    end

    // -----------------------------------------------------------------
    // Transmit path and control output
    // -----------------------------------------------------------------
    logic [15:0] cur_cco;
    wire  [3:0]  cco_idx = {bit_reg[2:0], ph_reg[1]};
    wire         cco_now = cur_cco[cco_idx];
    wire         drive_ok = OUTPUT_DRIVE_ENABLE_PIN & ~OUTPUT_STANDBY_BIT;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            for (int s = 0; s < S; s++) begin
                tx_sh[s]   <= 8'h00;
                cur_ctl[s] <= 5'h00;
            end
            SERIAL_OUT_STREAMS <= 16'h0000;
            SERIAL_OUT_OE      <= 16'h0000;
            CONTROL_BIT_OUTPUT <= 1'b0;
        end else begin
            for (int s = 0; s < S; s++) begin
                if (chan_start) begin
                    tx_sh[s]   <= nxt_byte[s];                      // [RULE2]
                    cur_ctl[s] <= nxt_ctl[s];
                end else if (bit_step) begin
                    tx_sh[s] <= {tx_sh[s][6:0], 1'b0};
                end
                SERIAL_OUT_STREAMS[s] <= tx_sh[s][7];               // [RULE22]
                SERIAL_OUT_OE[s] <= drive_ok & cur_ctl[s][3];       // [RULE12] [RULE13]
            end
            CONTROL_BIT_OUTPUT <= cco_now;                          // [RULE26]
        end
    end

    always_comb begin
        for (int s = 0; s < S; s++) begin
            cur_cco[s] = cur_ctl[s][2];
        end
    end

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    sequence s_fetch_run;
        fetch_run [*8] ##1 fetch_run [*8];
    endsequence
    property p_fetch_len;
        chan_start && !fetch_run |=> s_fetch_run ##1 !fetch_run;
    endproperty
    a_fetch_len: assert property (p_fetch_len) else $error("fetch length wrong"); // [RULE7]
    property p_restart;
        frame_pulse |=> bit_reg == 10'h000 && ph_reg == 2'h0;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart"); // [RULE27]
    property p_all_off;
        !drive_ok |=> SERIAL_OUT_OE == 16'h0000;
    endproperty
    a_all_off: assert property (p_all_off) else $error("outputs driven"); // [RULE13]
    property p_wide;
        WIDE_PULSE_ALIGNMENT_MODE |=> !GCI_FORMAT;
    endproperty
    a_wide: assert property (p_wide) else $error("wide mode format"); // [RULE16]
    property p_bit_range;
        bit_reg <= bit_last || $changed(DATA_RATE);
    endproperty
    a_bit_range: assert property (p_bit_range) else $error("bit count range"); // [RULE1]
    property p_proc_byte;
        pv_reg && pproc_reg |=> nxt_byte[$past(pidx_reg)] == $past(pdata_reg);
    endproperty
    a_proc_byte: assert property (p_proc_byte) else $error("proc byte lost"); // [RULE6]
    property p_cm_write;
        cm_wr |=> cm_mem[$past(cm_waddr)] == $past(HOST_WDATA);
    endproperty
    a_cm_write: assert property (p_cm_write) else $error("cm write lost"); // [RULE14]
    property p_cco;
        cco_now |=> CONTROL_BIT_OUTPUT;
    endproperty
    a_cco: assert property (p_cco) else $error("cco mismatch"); // [RULE26]
    property p_push;
        capture |=> push_act_reg && push_idx_reg == 4'h0;
    endproperty
    a_push: assert property (p_push) else $error("byte not queued"); // [RULE4]
endmodule

// >>> tb/tsi_stream_model.sv
/* Far side: master clock, frame pulse and 16 RX streams.
   Assumes 100 MHz ref_clk; 8 ref_clk a bit, 32 channels a frame. */
`timescale 1ns/1ps
module tsi_stream_model (
    input  wire logic   ref_clk,
    output logic        mclk,
    output logic        fsync_b,
    output logic [15:0] rx,
    output logic [2:0]  ph = 3'h0,
    output logic [7:0]  bit_idx = 8'h00,
    output logic [7:0]  frame_no = 8'h00
);
    logic [7:0] byte_val;
    // Falling edge at ph 0 is the bit boundary
    assign mclk = ph[1];
    // Low only around the bit 0 boundary, so the mid-bit edge never frames
    assign fsync_b = !(bit_idx == 8'h00 && !ph[2])
                  && !(bit_idx == 8'hff && ph[2:1] == 2'h3);
    assign byte_val = {frame_no[3:0], bit_idx[6:3]};
    assign rx = {16{byte_val[3'h7 - bit_idx[2:0]]}};
    always @(negedge ref_clk) begin
        ph <= ph + 3'h1;
        if (ph == 3'h7) begin
            bit_idx <= bit_idx + 8'h01;
            frame_no <= frame_no + {7'h00, bit_idx == 8'hff};
        end
    end
endmodule

// >>> tb/test_tsi_core.sv
/* Bench for the switch core at 2.048 Mb/s, stream 0 observed.
   Assumes tsi_stream_model as far side. */
`timescale 1ns/1ps
module test_tsi_core;
    logic        ref_clk, rst_b, output_drive_enable_pin, output_standby_bit, wide_sel, host_wr, host_rd, ack, gci, wide, control_bit_output;
    logic [1:0]  ms;
    logic [3:0]  h_strm;
    logic [7:0]  h_addr;
    logic [15:0] h_wdata, rdata, tx, tx_oe;
    logic [7:0]  cap [32];
    logic [31:0] oe_cap, cco_cap;
    wire         mclk, fsync_b;
    wire  [15:0] rx;
    wire  [2:0]  ph;
    wire  [7:0]  bit_idx, frame_no;
    int          n_errors, checks_done;
    localparam logic [15:0] oe_on = 16'h0001 << tsi_pkg::CM_OE;
    localparam logic [15:0] proc_on = 16'h0001 << tsi_pkg::CM_PROC;
    localparam logic [15:0] const_on = 16'h0001 << tsi_pkg::CM_CONST;
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    tsi_stream_model i_far (.ref_clk(ref_clk), .mclk(mclk), .fsync_b(fsync_b), .rx(rx),
        .ph(ph), .bit_idx(bit_idx), .frame_no(frame_no));
    tsi_core i_dut (.REF_CLK(ref_clk), .RST_B(rst_b), .MASTER_CLK(mclk),
        .FRAME_SYNC_IN(fsync_b), .RX_STREAMS(rx), .DATA_RATE(2'h0),
        .OUTPUT_DRIVE_ENABLE_PIN(output_drive_enable_pin), .OUTPUT_STANDBY_BIT(output_standby_bit),
        .WIDE_PULSE_SELECT_PIN(wide_sel), .FRAME_OFFSET(64'h0), .MEMORY_SELECT_BIT(ms),
        .HOST_STREAM(h_strm), .HOST_ADDR(h_addr), .HOST_WR(host_wr), .HOST_RD(host_rd),
        .HOST_WDATA(h_wdata), .SERIAL_OUT_STREAMS(tx), .SERIAL_OUT_OE(tx_oe),
        .CONTROL_BIT_OUTPUT(control_bit_output), .HOST_RDATA(rdata), .HOST_ACK(ack), .GCI_FORMAT(gci),
        .WIDE_PULSE_ALIGNMENT_MODE(wide));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic give_up(input int i, input int lim);
        if (i >= lim) check("timeout", 16'h0001, 16'h0000);
        if (i >= lim) report_and_stop();
    endtask
    // Address is {stream, channel}; reads wait for the acknowledge
    task automatic host_op(input logic rd, input logic [1:0] sel, input logic [11:0] a,
                           input logic [15:0] w);
        int i;
        @(negedge ref_clk);
        {ms, h_strm, h_addr, h_wdata} = {sel, a, w};
        {host_rd, host_wr} = {rd, !rd};
        @(negedge ref_clk);
        {host_rd, host_wr} = 2'h0;
        for (i = 0; rd && i < 30 && ack !== 1'b1; i++) @(negedge ref_clk);
        give_up(i, 30);
    endtask
    // Late in each bit cell, clear of the 1-2 cycle output lag
    task automatic capture(output logic [3:0] f);
        int i;
        for (i = 0; i < 3000 && !(bit_idx == 8'h00 && ph == 3'h7); i++) @(posedge ref_clk);
        give_up(i, 3000);
        f = frame_no[3:0];
        for (i = 0; i < 256; i++) begin
            cap[i / 8] = {cap[i / 8][6:0], tx[0]};
            oe_cap[i / 8] = tx_oe[0];
            if (i % 8 == 0) cco_cap[i / 8] = control_bit_output;
            repeat (8) @(posedge ref_clk);
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_switch;
        logic [3:0] f;
        // Reset leaves the connection memory unknown; blank the entries of streams 0 to 7 first
        for (int a = 0; a < 2048; a++) host_op(1'b0, tsi_pkg::MS_CM, a[11:0], 16'h0000);
        host_op(1'b0, tsi_pkg::MS_CM, 12'h104, 16'h0001 << tsi_pkg::CM_CCO);
        host_op(1'b0, tsi_pkg::MS_CM, 12'h004, proc_on | oe_on | 16'h00a5);
        host_op(1'b0, tsi_pkg::MS_CM, 12'h006, oe_on | 16'h0182);
        host_op(1'b0, tsi_pkg::MS_CM, 12'h003, oe_on | 16'h0182);
        host_op(1'b0, tsi_pkg::MS_CM, 12'h008, const_on | oe_on | 16'h0182);
        host_op(1'b0, tsi_pkg::MS_CM, 12'h00a, oe_on | 16'h0182);
        host_op(1'b0, tsi_pkg::MS_CM, 12'h00c, 16'h0000);
        repeat (3) capture(f);
        for (int k = 0; k < 2; k++) begin
            capture(f);
            check("proc", {8'h00, cap[4]}, 16'h00a5);
            check("same", {8'h00, cap[6]}, {8'h00, f, 4'h2});
            check("next", {8'h00, cap[3]}, {8'h00, f - 4'h1, 4'h2});
            check("const", {8'h00, cap[8]}, {8'h00, f - 4'h2, 4'h2});
            check("bcast", {8'h00, cap[10]}, {8'h00, f, 4'h2});
            check("oe_off", {15'h0000, oe_cap[12]}, 16'h0000);
            check("oe_on", {15'h0000, oe_cap[4]}, 16'h0001);
            check("cco_on", {15'h0000, cco_cap[4]}, 16'h0001);
            check("cco_off", {15'h0000, cco_cap[3]}, 16'h0000);
        end
    endtask
    task automatic t_host;
        host_op(1'b0, tsi_pkg::MS_CM, 12'h57f, 16'h2e5a);
        host_op(1'b1, tsi_pkg::MS_CM, 12'h57f, 16'h0000);
        check("cm", rdata, 16'h2e5a);
        host_op(1'b1, 2'h0, 12'h57f, 16'h0000);
        check("reg", rdata, 16'h0000);
        host_op(1'b1, tsi_pkg::MS_DM, 12'h302, 16'h0000);
        check("dm", rdata & 16'hff0f, 16'h0002);
    endtask
    task automatic t_drive;
        logic [3:0] f;
        for (int k = 0; k < 2; k++) begin
            @(negedge ref_clk);
            {output_drive_enable_pin, output_standby_bit} = k ? 2'h0 : 2'h3;
            capture(f);
            check("all_off", oe_cap[15:0], 16'h0000);
        end
    endtask
    initial begin
        {rst_b, output_drive_enable_pin, output_standby_bit, wide_sel, host_wr, host_rd} = 6'h10;
        {ms, h_strm, h_addr, h_wdata} = 30'h00000000;
        n_errors = 0;
        checks_done = 0;
        repeat (10) @(negedge ref_clk);
        check("rst_oe", tx_oe, 16'h0000);
        rst_b = 1'b1;
        t_switch();
        t_host();
        check("gci", {15'h0000, gci}, 16'h0000);
        t_drive();
        wide_sel = 1'b1;
        repeat (4) @(negedge ref_clk);
        check("wide", {15'h0000, wide}, 16'h0001);
        report_and_stop();
    end
endmodule
